// ---- verilog/qrx_pkg.sv ----
// shared constants and state types for the quad read sequencer ends
// assumes a single 25 MHz clock on both ends and a 4-bit link
// Overview of operation
// (RQ1) opcode: clocks 0-7 quad SPI, 0-1 four-line
// (RQ2) opcode EBh is quad address/data read
// (RQ3) address, mode, first data slots after opcode
// (RQ4) mode byte sets continuous read, next access
// (RQ5) without continuous read, host resends opcode
// (RQ6) continuous read: next access skips opcode
// (RQ7) opcode-free: address 0-5, mode 6-7, data 8-9
// (RQ8) last opcode stays active during continuous read
// (RQ9) mode byte FFh ends continuous read mode
// (RQ10) host releases lines before second mode fall
// (RQ11) device streams bytes until chip select rises
// (RQ12) continuous read cleared after reset
package qrx_pkg;
  localparam logic [7:0] OPC_QUAD_ADDR_DATA_READ = 8'hEB;
  localparam logic [7:0] MODE_BYTE_EXIT          = 8'hFF;
  localparam logic [4:0] OPC_CLKS_QUAD_SPI       = 5'h08;
  localparam logic [4:0] OPC_CLKS_FOUR_LINE      = 5'h02;
  localparam logic [4:0] ADDR_CLKS               = 5'h06;
  localparam logic [4:0] MODE_CLKS               = 5'h02;
  localparam logic [4:0] HDR_CLKS                = ADDR_CLKS + MODE_CLKS;
  localparam logic [4:0] CNT_ONE                 = 5'h01;
  localparam int         CLK_HZ                  = 25_000_000;
  localparam int         SCK_HALF_NS             = 160;
  localparam int         SCK_HALF_CYC            =
    (SCK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int         CS_HIGH_NS              = 320;
  localparam int         CS_HIGH_CYC             =
    (CS_HIGH_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [3:0] PH_ZERO                 = 4'h0;
  localparam logic [3:0] PH_ONE                  = 4'h1;
  localparam logic [3:0] PH_RISE                 = 4'(SCK_HALF_CYC);
  localparam logic [3:0] PH_LAST                 = 4'(2 * SCK_HALF_CYC - 1);
  localparam logic [3:0] CS_HIGH_LAST            = 4'(CS_HIGH_CYC - 1);
  localparam int         FIFO_DEPTH              = 4;
  localparam int         BYTE_W                  = 8;

  typedef enum logic [5:0] {
    QRX_D_IDLE   = 6'h01,
    QRX_D_OPCODE = 6'h02,
    QRX_D_ADDR   = 6'h04,
    QRX_D_MODE   = 6'h08,
    QRX_D_DATA   = 6'h10,
    QRX_D_IGNORE = 6'h20
  } qrx_dev_state_t;

  typedef enum logic [3:0] {
    QRX_H_IDLE  = 4'h1,
    QRX_H_SETUP = 4'h2,
    QRX_H_XFER  = 4'h4,
    QRX_H_HOLD  = 4'h8
  } qrx_host_state_t;
endpackage : qrx_pkg

// ---- verilog/qrx_link_if.sv ----
// link between host controller and memory-side sequencer
// assumes undriven data lines float high through a pull-up
interface qrx_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (host_io_oe[i]) begin
        io[i] = host_io_out[i];
      end else if (dev_io_oe[i]) begin
        io[i] = dev_io_out[i];
      end else begin
        io[i] = 1'b1;
      end
    end
  end

  modport host (output cs_n, output sclk, output host_io_out,
                output host_io_oe, input io);
  modport device (input cs_n, input sclk, input io,
                  output dev_io_out, output dev_io_oe);
endinterface : qrx_link_if

// ---- verilog/qrx_device.sv ----
// memory-side command sequencer for quad address/data reads
// assumes the link pins are asynchronous and sampled through two flops;
// the user side serves rd_data_in for rd_addr_out without delay
module qrx_device
  import qrx_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  qrx_link_if.device      link,
  input  wire logic       four_line_command_mode_in,
  input  wire logic [7:0] rd_data_in,
  output logic      [23:0] rd_addr_out,
  output logic             byte_taken_out,
  output logic             access_active_out,
  output logic             continuous_read_mode_out,
  output logic      [7:0]  active_opcode_out,
  output logic      [7:0]  continuation_mode_byte_out
);
  logic [5:0]     pin_s1;
  logic [5:0]     pin_s2;
  logic [1:0]     pin_prev;
  logic           cs_low;
  logic           sck_rise;
  logic           sck_fall;
  logic           cs_rise;
  logic [3:0]     io_s;
  qrx_dev_state_t state;
  logic [4:0]     cnt;
  logic [23:0]    rx_sh;
  logic [7:0]     next_opcode;
  logic [7:0]     next_byte;
  logic           opcode_done;
  logic           addr_done;
  logic           mode_done;
  logic           pend_valid;
  logic           pend_xip;
  logic           half;
  logic [3:0]     tx_low;
  logic [3:0]     io_out;
  logic           io_en;

  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // idle pin levels, so that release of reset shows no false edge
      pin_s1   <= 6'h2F;
      pin_s2   <= 6'h2F;
      pin_prev <= 2'h2;
    end else begin
      pin_s1   <= {link.cs_n, link.sclk, link.io};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2[5:4];
    end
  end

  assign io_s     = pin_s2[3:0];
  assign cs_low   = ~pin_s2[5];
  assign sck_rise = pin_s2[4] & ~pin_prev[0] & cs_low;
  assign sck_fall = ~pin_s2[4] & pin_prev[0] & cs_low;
  assign cs_rise  = pin_s2[5] & ~pin_prev[1];

  // opcode travels on io0 alone in quad SPI, four lines otherwise
  assign next_opcode = four_line_command_mode_in ? {rx_sh[3:0], io_s}
                                                 : {rx_sh[6:0], io_s[0]};
  assign next_byte   = {rx_sh[3:0], io_s};
  assign opcode_done = sck_rise && (state == QRX_D_OPCODE) &&
    (cnt == (four_line_command_mode_in ? OPC_CLKS_FOUR_LINE - CNT_ONE
                                       : OPC_CLKS_QUAD_SPI - CNT_ONE)); // [RQ1]
  assign addr_done   = sck_rise && (state == QRX_D_ADDR) &&
                       (cnt == ADDR_CLKS - CNT_ONE); // [RQ3] [RQ7]
  assign mode_done   = sck_rise && (state == QRX_D_MODE) &&
                       (cnt == MODE_CLKS - CNT_ONE); // [RQ3] [RQ7]

  // receive sequencing; chip select high always ends the access
  always_ff @(posedge clk_in) begin
    if (reset_in || !cs_low) begin
      state <= QRX_D_IDLE;
      cnt   <= 5'h00;
      rx_sh <= 24'h000000;
    end else begin
      case (state)
        QRX_D_IDLE: begin
          cnt   <= 5'h00;
          // continuous read: address from the very first clock
          state <= continuous_read_mode_out ? QRX_D_ADDR
                                            : QRX_D_OPCODE; // [RQ6] [RQ5]
        end
        QRX_D_OPCODE: begin
          if (sck_rise) begin
            rx_sh <= {16'h0000, next_opcode};
            cnt   <= cnt + CNT_ONE;
            if (opcode_done) begin
              cnt   <= 5'h00;
              state <= (next_opcode == OPC_QUAD_ADDR_DATA_READ)
                       ? QRX_D_ADDR : QRX_D_IGNORE; // [RQ2]
            end
          end
        end
        QRX_D_ADDR: begin
          if (sck_rise) begin
            rx_sh <= {rx_sh[19:0], io_s};
            cnt   <= cnt + CNT_ONE;
            if (addr_done) begin
              cnt   <= 5'h00;
              state <= QRX_D_MODE;
            end
          end
        end
        QRX_D_MODE: begin
          if (sck_rise) begin
            rx_sh <= {rx_sh[19:0], io_s};
            cnt   <= cnt + CNT_ONE;
            if (mode_done) begin
              cnt   <= 5'h00;
              state <= QRX_D_DATA;
            end
          end
        end
        QRX_D_DATA: begin
          state <= QRX_D_DATA; // [RQ11]
        end
        QRX_D_IGNORE: begin
          state <= QRX_D_IGNORE;
        end
        default: begin
          state <= QRX_D_IDLE;
        end
      endcase
    end
  end

  // opcode survives across accesses for continuous read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      active_opcode_out <= 8'h00;
    end else if (opcode_done) begin
      active_opcode_out <= next_opcode; // [RQ8]
    end
  end

  // mode byte takes effect only once the current access has ended
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      continuous_read_mode_out   <= 1'b0; // [RQ12]
      pend_valid                 <= 1'b0;
      pend_xip                   <= 1'b0;
      continuation_mode_byte_out <= 8'h00;
    end else begin
      if (mode_done) begin
        continuation_mode_byte_out <= next_byte;
        pend_valid                 <= 1'b1;
        pend_xip <= (next_byte != MODE_BYTE_EXIT); // [RQ4] [RQ9]
      end else if (cs_rise) begin
        pend_valid <= 1'b0;
        if (pend_valid) begin
          continuous_read_mode_out <= pend_xip; // [RQ4] [RQ9]
        end
      end
    end
  end

  // read data changes on falling edges, high nibble first
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_addr_out    <= 24'h000000;
      half           <= 1'b0;
      tx_low         <= 4'h0;
      io_out         <= 4'h0;
      io_en          <= 1'b0;
      byte_taken_out <= 1'b0;
    end else begin
      byte_taken_out <= 1'b0;
      if (!cs_low) begin
        half  <= 1'b0;
        io_en <= 1'b0;
      end else if (addr_done) begin
        rd_addr_out <= {rx_sh[19:0], io_s};
      end else if (sck_fall && state == QRX_D_DATA) begin
        io_en <= 1'b1;
        if (!half) begin
          io_out         <= rd_data_in[7:4]; // [RQ11]
          tx_low         <= rd_data_in[3:0];
          half           <= 1'b1;
          byte_taken_out <= 1'b1;
        end else begin
          io_out      <= tx_low;
          half        <= 1'b0;
          rd_addr_out <= rd_addr_out + 24'h000001; // [RQ11]
        end
      end
    end
  end

  // host has released the lines by now; no contention
  assign link.dev_io_out   = io_out; // [RQ10]
  assign link.dev_io_oe    = {4{io_en}};
  assign access_active_out = cs_low;
endmodule : qrx_device

// ---- verilog/qrx_host.sv ----
// host controller end of the quad address/data read link, with its
// read-data FIFO; makes the serial clock by dividing its own clock
module qrx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != CW'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule : qrx_fifo

module qrx_host
  import qrx_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  qrx_link_if.host         link,
  input  wire logic        four_line_command_mode_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [23:0] req_addr_in,
  input  wire logic [7:0]  req_mode_in,
  input  wire logic [7:0]  req_len_in,
  output logic             rd_valid_out,
  input  wire logic        rd_ready_in,
  output logic      [7:0]  rd_data_out,
  output logic             continuous_read_mode_out
);
  logic [3:0]      io_s1;
  logic [3:0]      io_s2;
  qrx_host_state_t state;
  logic [3:0]      ph;
  logic [4:0]      slot;
  logic [4:0]      opc_clks;
  logic [4:0]      hdr_end;
  logic [7:0]      op_sh;
  logic [31:0]     am_sh;
  logic [7:0]      mode_sent;
  logic [7:0]      left;
  logic [3:0]      rx_hi;
  logic            nib;
  logic            push;
  logic [7:0]      push_data;
  logic            fifo_ready;
  logic            stall;
  logic            in_data;

  // opcode clocks for the coming access; none in continuous read
  function automatic logic [4:0] opc_len(input logic cont,
                                         input logic four);
    if (cont) begin
      return 5'h00;
    end else if (four) begin
      return OPC_CLKS_FOUR_LINE;
    end
    return OPC_CLKS_QUAD_SPI;
  endfunction : opc_len

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      io_s1 <= 4'hF;
      io_s2 <= 4'hF;
    end else begin
      io_s1 <= link.io;
      io_s2 <= io_s1;
    end
  end

  assign req_ready_out = (state == QRX_H_IDLE);
  assign in_data       = (slot >= hdr_end);
  // serial clock held low while the FIFO has no room for a byte; a push
  // still in flight is not yet counted, so it waits a cycle as well
  assign stall = (state == QRX_H_XFER) && in_data && !nib &&
                 (ph == PH_ZERO) && (!fifo_ready || push);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state     <= QRX_H_IDLE;
      ph        <= PH_ZERO;
      slot      <= 5'h00;
      opc_clks  <= 5'h00;
      hdr_end   <= HDR_CLKS;
      op_sh     <= 8'h00;
      am_sh     <= 32'h00000000;
      mode_sent <= 8'h00;
      left      <= 8'h00;
      rx_hi     <= 4'h0;
      nib       <= 1'b0;
      push      <= 1'b0;
      push_data <= 8'h00;
      link.cs_n        <= 1'b1;
      link.sclk        <= 1'b0;
      link.host_io_out <= 4'h0;
      link.host_io_oe  <= 4'h0;
      continuous_read_mode_out <= 1'b0;
    end else begin
      push <= 1'b0;
      case (state)
        QRX_H_IDLE: begin
          if (req_valid_in) begin
            // opcode only when the device is not in continuous read
            opc_clks <= opc_len(continuous_read_mode_out,
                                four_line_command_mode_in); // [RQ5] [RQ6]
            hdr_end  <= opc_len(continuous_read_mode_out,
                                four_line_command_mode_in)
                        + HDR_CLKS; // [RQ3] [RQ7]
            op_sh     <= OPC_QUAD_ADDR_DATA_READ;
            am_sh     <= {req_addr_in, req_mode_in};
            mode_sent <= req_mode_in;
            left      <= req_len_in - 8'h01;
            slot      <= 5'h00;
            ph        <= PH_ZERO;
            nib       <= 1'b0;
            link.cs_n <= 1'b0;
            state     <= QRX_H_SETUP;
          end
        end
        QRX_H_SETUP: begin
          ph <= ph + PH_ONE;
          if (ph == PH_LAST) begin
            ph    <= PH_ZERO;
            state <= QRX_H_XFER;
          end
        end
        QRX_H_XFER: begin
          if (!stall) begin
            ph <= (ph == PH_LAST) ? PH_ZERO : ph + PH_ONE;
          end
          if (ph == PH_ZERO && slot < opc_clks) begin
            if (four_line_command_mode_in) begin
              link.host_io_out <= op_sh[7:4]; // [RQ1]
              link.host_io_oe  <= 4'hF;
              op_sh            <= {op_sh[3:0], 4'h0};
            end else begin
              link.host_io_out <= {3'b000, op_sh[7]}; // [RQ1]
              link.host_io_oe  <= 4'h1;
              op_sh            <= {op_sh[6:0], 1'b0};
            end
          end else if (ph == PH_ZERO && !in_data) begin
            link.host_io_out <= am_sh[31:28]; // [RQ3] [RQ7]
            link.host_io_oe  <= 4'hF;
            am_sh            <= {am_sh[27:0], 4'h0};
          end
          if (ph == PH_RISE) begin
            link.sclk <= 1'b1;
          end
          // release in the high half of the last mode clock, once the
          // device has sampled it and before the clock falls
          if (ph == PH_LAST - PH_ONE && slot == hdr_end - CNT_ONE) begin
            link.host_io_oe <= 4'h0; // [RQ10]
          end
          if (ph == PH_LAST) begin
            link.sclk <= 1'b0;
            if (!in_data) begin
              slot <= slot + CNT_ONE;
            end
            if (in_data) begin
              nib <= ~nib;
              if (!nib) begin
                rx_hi <= io_s2;
              end else begin
                push      <= 1'b1;
                push_data <= {rx_hi, io_s2};
                left      <= left - 8'h01;
                if (left == 8'h00) begin
                  link.cs_n <= 1'b1;
                  ph        <= PH_ZERO;
                  state     <= QRX_H_HOLD;
                  continuous_read_mode_out <=
                    (mode_sent != MODE_BYTE_EXIT); // [RQ9] [RQ4]
                end
              end
            end
          end
        end
        QRX_H_HOLD: begin
          ph <= ph + PH_ONE;
          if (ph == CS_HIGH_LAST) begin
            state <= QRX_H_IDLE;
          end
        end
        default: begin
          state <= QRX_H_IDLE;
        end
      endcase
    end
  end

  qrx_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_data),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );
endmodule : qrx_host

// ---- sim/qrx_link_monitor.sv ----
// assertion checker watching the link between host and device ends
// assumes one clock domain and the testbench wiring it beside the link
module qrx_link_monitor
  import qrx_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        sclk_q;
  logic [15:0] rise_cnt;
  logic [15:0] cnt_now;

  // count includes a rise seen this cycle, so oe timing needs no guess
  assign cnt_now = rise_cnt + {15'h0000, sclk & ~sclk_q};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || cs_n) begin
      rise_cnt <= 16'h0000;
    end else begin
      rise_cnt <= cnt_now;
    end
  end

  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_ONE_DRIVER: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("host and device drive one io line together");
  AST_IO_RESOLVE: assert property (
    io == ((host_io_out & host_io_oe) | (dev_io_out & dev_io_oe) |
           ~(host_io_oe | dev_io_oe)))
    else $error("io lines do not show the driving end");
  AST_HOST_LET_GO: assert property ($fell(|host_io_oe) |->
    sclk && cnt_now inside {16'h0008, 16'h000A, 16'h0010})
    else $error("host released io outside last header clock high");
  AST_DEV_TURN_ON: assert property ($rose(|dev_io_oe) |->
    !sclk && !cs_n && cnt_now inside {16'h0008, 16'h000A, 16'h0010})
    else $error("device began driving at a wrong clock");
  AST_DEV_QUIET: assert property (cs_n [*5] |-> dev_io_oe == 4'h0)
    else $error("device drives io while deselected");
  AST_DEV_STAYS: assert property ($fell(|dev_io_oe) |-> cs_n)
    else $error("device stopped driving before chip select rose");
  AST_DEV_HOLD_HIGH: assert property (
    sclk && $past(sclk) && (|dev_io_oe) |-> $stable(dev_io_out))
    else $error("device data moved while serial clock high");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*3] ##1 !sclk)
    else $error("serial clock high phase not three cycles");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("chip select high time too short");
  AST_SCLK_PARK: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
endmodule : qrx_link_monitor

// ---- sim/quad_read_xip_sequencer_test.sv ----
// self-checking bench: host and device ends joined by one link, plus a
// second device fed a foreign opcode by a small bench driver
module quad_read_xip_sequencer_test;
  import qrx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] BAD_OPC = 8'h3C;

  logic        clk_in = 1'b0;
  logic        reset_in;
  logic        four_line;
  logic [7:0]  rd_feed;
  logic        req_valid;
  logic        req_ready;
  logic [23:0] req_addr;
  logic [7:0]  req_mode;
  logic [7:0]  req_len;
  logic        rd_valid;
  logic        rd_ready;
  logic [7:0]  rd_byte;
  logic        host_cont;
  logic [23:0] dev_addr;
  logic        dev_cont;
  logic [7:0]  dev_opc;
  logic [7:0]  dev_mode;
  logic        dev_taken;
  logic        dev_active;
  logic        bad_cont;
  logic        bad_drive;
  logic        sclk_q;
  logic [3:0]  nibs [$];
  logic [7:0]  got [$];
  int          err_total;
  int          checks_done;
  int          cyc;
  int          n_taken;

  qrx_link_if link ();
  qrx_link_if link2 ();

  qrx_host qrx_host_inst (.clk_in(clk_in), .reset_in(reset_in), .link(link),
    .four_line_command_mode_in(four_line), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_addr_in(req_addr),
    .req_mode_in(req_mode), .req_len_in(req_len), .rd_valid_out(rd_valid),
    .rd_ready_in(rd_ready), .rd_data_out(rd_byte),
    .continuous_read_mode_out(host_cont));

  qrx_device qrx_device_inst (.clk_in(clk_in), .reset_in(reset_in),
    .link(link), .four_line_command_mode_in(four_line),
    .rd_data_in(rd_feed), .rd_addr_out(dev_addr),
    .byte_taken_out(dev_taken), .access_active_out(dev_active),
    .continuous_read_mode_out(dev_cont),
    .active_opcode_out(dev_opc), .continuation_mode_byte_out(dev_mode));

  qrx_device qrx_device_inst2 (.clk_in(clk_in), .reset_in(reset_in),
    .link(link2), .four_line_command_mode_in(1'b0), .rd_data_in(8'h00),
    .rd_addr_out(), .byte_taken_out(), .access_active_out(),
    .continuous_read_mode_out(bad_cont), .active_opcode_out(),
    .continuation_mode_byte_out());

  qrx_link_monitor qrx_link_monitor_inst (.clk_in(clk_in),
    .reset_in(reset_in), .cs_n(link.cs_n), .sclk(link.sclk),
    .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
    .dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe),
    .io(link.io));

  always #20 clk_in = ~clk_in;

  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : pat

  always @(posedge clk_in) begin
    rd_feed <= pat(dev_addr);
    sclk_q <= link.sclk;
    if (link.sclk && !sclk_q && !link.cs_n)
      nibs.push_back(link.io);
    if (rd_valid && rd_ready)
      got.push_back(rd_byte);
    if (dev_taken)
      n_taken <= n_taken + 1;
    if (!reset_in && link2.dev_io_oe !== 4'h0)
      bad_drive <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_go(input logic [23:0] a, input logic [7:0] m,
                       input logic [7:0] n);
    nibs = {};
    got = {};
    n_taken = 0;
    while (req_ready !== 1'b1)
      @(negedge clk_in);
    @(posedge clk_in);
    req_valid <= 1'b1;
    req_addr <= a;
    req_mode <= m;
    req_len <= n;
    @(posedge clk_in);
    req_valid <= 1'b0;
  endtask : rd_go

  task automatic rd_end(input logic [23:0] a, input logic [7:0] m,
                        input int n, input int oc);
    int         i;
    logic [7:0] e;
    while (got.size() < n || link.cs_n !== 1'b1)
      @(negedge clk_in);
    // device sees chip select through a synchroniser
    repeat (4) @(negedge clk_in);
    chk(24'(nibs.size()), 24'(oc + 8 + 2 * n));
    for (i = 0; i < 8 && oc == 8; i++)
      chk(24'(nibs[i][0]), 24'(OPC_QUAD_ADDR_DATA_READ[7 - i]));
    if (oc == 2)
      chk(24'({nibs[0], nibs[1]}), 24'(OPC_QUAD_ADDR_DATA_READ));
    for (i = 0; i < 6; i++)
      chk(24'(nibs[oc + i]), 24'(a[23 - 4 * i -: 4]));
    for (i = 0; i < 2; i++)
      chk(24'(nibs[oc + 6 + i]), 24'(m[7 - 4 * i -: 4]));
    for (i = 0; i < n; i++) begin
      e = pat(a + 24'(i));
      chk(24'(got[i]), 24'(e));
      chk(24'({nibs[oc + 8 + 2 * i], nibs[oc + 9 + 2 * i]}), 24'(e));
    end
    chk(24'(dev_opc), 24'(OPC_QUAD_ADDR_DATA_READ));
    chk(24'(dev_mode), 24'(m));
    chk(24'(dev_cont), 24'(m != MODE_BYTE_EXIT));
    chk(24'(host_cont), 24'(m != MODE_BYTE_EXIT));
    chk(24'(n_taken), 24'(n));
    chk(dev_addr, a + 24'(n));
    chk(24'(dev_active), 24'h000000);
  endtask : rd_end

  task automatic rd(input logic [23:0] a, input logic [7:0] m, input int n,
                    input int oc);
    rd_go(a, m, 8'(n));
    rd_end(a, m, n, oc);
  endtask : rd

  // eight-bit foreign opcode, one bit per clock on io0, then lines released before the sixteenth clock, where a read holds them into its high half
  task automatic bad_frame();
    int i;
    @(posedge clk_in);
    link2.cs_n <= 1'b0;
    for (i = 0; i < 24; i++) begin
      @(posedge clk_in);
      link2.host_io_out <= (i < 8) ? {3'h0, BAD_OPC[7 - i]} : 4'hA;
      link2.host_io_oe <= (i < 15) ? 4'hF : 4'h0;
      repeat (4) @(posedge clk_in);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge clk_in);
      link2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    link2.cs_n <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask : bad_frame

  initial begin
    reset_in = 1'b1;
    four_line = 1'b0;
    req_valid = 1'b0;
    req_addr = 24'h000000;
    req_mode = 8'h00;
    req_len = 8'h00;
    rd_ready = 1'b1;
    bad_drive = 1'b0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    n_taken = 0;
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.host_io_out = 4'h0;
    link2.host_io_oe = 4'h0;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    chk(24'(dev_cont), 24'h000000);
    chk(24'(host_cont), 24'h000000);
    rd(24'h000100, 8'hFF, 3, 8);
    rd(24'h000200, 8'hFF, 2, 8);
    rd(24'h012340, 8'h20, 4, 8);
    rd(24'h0ABC00, 8'h00, 2, 0);
    rd(24'h0ABC10, 8'hFF, 1, 0);
    rd(24'h000400, 8'hFF, 2, 8);
    @(posedge clk_in) four_line <= 1'b1;
    rd(24'h00F000, 8'h5A, 2, 2);
    rd(24'h00F100, 8'hFF, 3, 0);
    rd(24'h00F200, 8'hFF, 1, 2);
    @(posedge clk_in) four_line <= 1'b0;
    rd(24'h030000, 8'hFF, 256, 8);
    @(posedge clk_in) rd_ready <= 1'b0;
    rd_go(24'h020000, 8'hFF, 8'h08);
    repeat (800) @(negedge clk_in);
    chk(24'(got.size()), 24'h000000);
    chk(24'(link.cs_n), 24'h000000);
    chk(24'(link.sclk), 24'h000000);
    chk(24'(rd_valid), 24'h000001);
    chk(24'(n_taken), 24'h000005);
    chk(24'(dev_active), 24'h000001);
    @(posedge clk_in) rd_ready <= 1'b1;
    rd_end(24'h020000, 8'hFF, 8, 8);
    bad_frame();
    chk(24'(bad_drive), 24'h000000);
    chk(24'(bad_cont), 24'h000000);
    wrap_up();
  end
endmodule : quad_read_xip_sequencer_test
